/* src/eeprom_pkg.sv */
// Constants and types shared by the serial EEPROM slave and its write FIFO.
// Assumes a 100 MHz system clock that samples the two-wire bus pins.
package eeprom_pkg;

  localparam int          CLK_HZ       = 100_000_000;
  // Internal non-volatile programming time, in milliseconds.
  localparam int          T_PROG_MS    = 5;
  localparam int          PROG_CYCLES  = T_PROG_MS * (CLK_HZ / 1000);
  localparam int          MEM_BYTES    = 256;
  localparam int          PAGE_BYTES   = 16;
  localparam int          FIFO_DEPTH   = 32;
  // Write FIFO word: page offset in the top four bits, data byte below.
  localparam int          FIFO_W       = 12;
  localparam int          OFF_LSB      = 8;
  localparam logic [3:0]  BIT_LAST_RX  = 4'h7;
  localparam logic [3:0]  BIT_LAST_TX  = 4'h8;
  localparam logic [7:0]  ADDR_RESET   = 8'h00;
  // Device-type code matched in the slave address; value is arbitrary.
  localparam logic [3:0]  DEV_TYPE_DEF = 4'h6;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_DEV       = 4'h1,
    ST_DEV_ACK   = 4'h3,
    ST_WADDR     = 4'h2,
    ST_WADDR_ACK = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hc,
    ST_WAIT_STOP = 4'hd
  } bus_state_e;

endpackage

/* src/eeprom_slave.sv */
// Two-wire serial EEPROM slave: 256-byte array, 16-byte page writes, reads.
// Assumes the bus pins, write-protect and supervisor reset are asynchronous
// to clk and are synchronised here; the bus wire resolves sda_oe outside.
//
// Operation
// R1: The receiver of a byte pulls data low during the ninth clock.
// R2: Acknowledge matching slave address, and every written byte when selected.
// R3: In reads shift out eight bits, release data, sample master acknowledge.
// R4: Master leaves ninth bit high: stop sending, wait for STOP.
// R5: Master byte write: START, address, memory address, data, STOP.
// R6: STOP ending a write starts programming; requests are ignored meanwhile.
// R7: A page write carries up to sixteen bytes in one cycle.
// R8: After each written byte only the low address bits increment.
// R9: Over sixteen bytes the offset wraps and overwrites buffered bytes.
// R10: STOP after a page write commits all buffered bytes at once.
// R11: Address polling gets no acknowledge while programming, then acknowledge.
// R12: Write-protect high: no acknowledge on first data byte, nothing programmed.
// R13: Master opens a read like a write with direction bit one.
// R14: Address counter holds last accessed address plus one.
// R15: Counter rolls from 255 to zero and reading continues.
// R16: Master ends a read by withholding acknowledge then STOP.
// R17: Random read: dummy write of address, repeated START, read.
// R18: Sequential read sends another byte after each master acknowledge.
// R19: Reads increment the whole address counter.
// R20: Slave address holds a four-bit type code; lowest bit is direction.
// R21: Supervisor reset aborts transfers but lets programming finish.
// R22: Low four address bits are page offset, high four the page.
// R23: Programming time is a parameter; busy flag spans it.
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int         PROG_CYC = PROG_CYCLES,
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Two-wire bus pins.
  input  wire logic scl_pin,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Side inputs and status.
  input  wire logic wp_pin,
  input  wire logic sup_reset,
  output logic      busy
);
  localparam int CW = $clog2(PROG_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // R15 wraps past top
  function automatic logic [7:0] inc_full(input logic [7:0] a);
    return a + 8'h01;
  endfunction
  function automatic logic [7:0] inc_page(input logic [7:0] a);
    return {a[7:4], a[3:0] + 4'h1};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection.

  logic       scl_q1, scl_q2, scl_prev;
  logic       sda_q1, sda_q2, sda_prev;
  logic       wp_q1, wp_s;
  logic       sup_q1, sup_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_q2, scl_q1, scl_prev} <= 3'h7;
      {sda_q2, sda_q1, sda_prev} <= 3'h7;
      {wp_s, wp_q1}              <= 2'h0;
      {sup_s, sup_q1}            <= 2'h0;
    end else begin
      {scl_q2, scl_q1} <= {scl_q1, scl_pin};
      {sda_q2, sda_q1} <= {sda_q1, sda_in};
      {wp_s, wp_q1}    <= {wp_q1, wp_pin};
      {sup_s, sup_q1}  <= {sup_q1, sup_reset};
      scl_prev         <= scl_q2;
      sda_prev         <= sda_q2;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;

  assign scl_rise  = scl_q2 && !scl_prev;
  assign scl_fall  = !scl_q2 && scl_prev;
  assign start_det = scl_q2 && scl_prev && sda_prev && !sda_q2;
  assign stop_det  = scl_q2 && scl_prev && !sda_prev && sda_q2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus protocol engine.

  bus_state_e  state;
  logic [7:0]  sh;
  logic [3:0]  bitcnt;
  logic        sda_drive;
  logic        ack_en;
  logic        ack_phase;
  logic        rd_mode;
  logic [7:0]  addr;
  logic        got_data;
  logic [7:0]  rx_byte;
  logic [7:0]  mem_rd;
  logic        byte_in;
  logic        push_valid;
  logic        push_ready;
  logic [7:0]  mem [MEM_BYTES];

  assign rx_byte    = {sh[6:0], sda_q2};
  assign mem_rd     = mem[addr];
  assign byte_in    = scl_rise && (bitcnt == BIT_LAST_RX);
  assign push_valid = (state == ST_WDATA) && byte_in && !wp_s && !sup_s && !stop_det
                      && !start_det;
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_drive;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      sh        <= 8'h00;
      bitcnt    <= 4'h0;
      sda_drive <= 1'b0;
      ack_en    <= 1'b0;
      ack_phase <= 1'b0;
      rd_mode   <= 1'b0;
      addr      <= ADDR_RESET;
      got_data  <= 1'b0;
    // R21 abort on reset
    end else if (sup_s || stop_det) begin
      state     <= ST_IDLE;
      sda_drive <= 1'b0;
      ack_phase <= 1'b0;
      got_data  <= 1'b0;
    end else if (start_det) begin
      state     <= ST_DEV;
      bitcnt    <= 4'h0;
      sda_drive <= 1'b0;
      ack_phase <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_WAIT_STOP: begin
        end
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (scl_rise) begin
            sh     <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_in) begin
            if (state == ST_DEV) begin
              // R20 type code match
              // R11 refuse while busy
              ack_en  <= (rx_byte[7:4] == DEV_TYPE) && !busy;
              rd_mode <= rx_byte[0];
              state   <= ST_DEV_ACK;
            end else if (state == ST_WADDR) begin
              // R2 acknowledge address
              ack_en <= 1'b1;
              // R17 random read address
              addr   <= rx_byte;
              state  <= ST_WADDR_ACK;
            end else begin
              // R12 protect refuses data
              ack_en <= !wp_s && push_ready;
              state  <= ST_WDATA_ACK;
              if (!wp_s && push_ready) begin
                // R8 page address increment
                addr     <= inc_page(addr);
                got_data <= 1'b1;
              end
            end
          end
        end
        ST_DEV_ACK, ST_WADDR_ACK, ST_WDATA_ACK: begin
          if (scl_fall && !ack_phase) begin
            // R1 drive acknowledge
            ack_phase <= 1'b1;
            sda_drive <= ack_en;
          end else if (scl_fall) begin
            ack_phase <= 1'b0;
            sda_drive <= 1'b0;
            bitcnt    <= 4'h0;
            if (!ack_en) begin
              state <= ST_WAIT_STOP;
            end else if (state == ST_DEV_ACK && rd_mode) begin
              // R14 counter holds next
              sh        <= mem_rd;
              sda_drive <= !mem_rd[7];
              addr      <= inc_full(addr);
              state     <= ST_RDATA;
            end else if (state == ST_DEV_ACK) begin
              state <= ST_WADDR;
            end else begin
              state <= ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == BIT_LAST_TX) begin
            // R3 release for acknowledge
            sda_drive <= 1'b0;
            bitcnt    <= 4'h0;
            state     <= ST_RACK;
          end else if (scl_fall) begin
            sh        <= {sh[6:0], 1'b0};
            sda_drive <= !sh[6];
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ack_en <= !sda_q2;
          end else if (scl_fall && ack_en) begin
            // R18 next byte on acknowledge
            // R19 full counter increment
            sh        <= mem_rd;
            sda_drive <= !mem_rd[7];
            addr      <= inc_full(addr);
            state     <= ST_RDATA;
          end else if (scl_fall) begin
            // R4 no acknowledge ends read
            state <= ST_WAIT_STOP;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write FIFO between the bus engine and the page buffer.

  logic [FIFO_W-1:0] pop_data;
  logic              pop_valid;
  logic              pop_ready;
  logic              prog_run;

  // Draining stalls while the array is being programmed; no bytes arrive then,
  // since the slave address is refused while busy, so the FIFO never fills.
  assign pop_ready = !prog_run;

  write_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_write_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (sup_s && !busy),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({addr[3:0], rx_byte}),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer, programming timer and memory array.

  logic [7:0]            pgbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pgval;
  logic [3:0]            page;
  logic [CW-1:0]         prog_cnt;
  logic                  commit;
  assign commit = busy && !prog_run && !pop_valid;

  // R9 later bytes overwrite
  always_ff @(posedge clk) begin
    if (pop_valid && pop_ready) begin
      pgbuf[pop_data[OFF_LSB+3:OFF_LSB]] <= pop_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pgval <= '0;
      page  <= 4'h0;
    end else begin
      if (commit || (sup_s && !busy)) begin
        pgval <= '0;
      end else if (pop_valid && pop_ready) begin
        pgval[pop_data[OFF_LSB+3:OFF_LSB]] <= 1'b1;
      end
      if (push_valid && push_ready) begin
        // R22 page select bits
        page <= addr[7:4];
      end
    end
  end

  // R10 single commit
  // R7 sixteen bytes per cycle
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pgval[i]) begin
          mem[{page, 4'(i)}] <= pgbuf[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      prog_run <= 1'b0;
      prog_cnt <= '0;
    end else if (!busy) begin
      // R6 start programming on STOP
      if (stop_det && got_data && !sup_s) begin
        busy     <= 1'b1;
        prog_cnt <= '0;
      end
    end else if (!prog_run) begin
      prog_run <= !pop_valid;
    // R23 timed busy period
    end else if (prog_cnt == CW'(PROG_CYC - 1)) begin
      busy     <= 1'b0;
      prog_run <= 1'b0;
    end else begin
      prog_cnt <= prog_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  busy_addr_nack_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (state == ST_DEV && byte_in && busy && !sup_s && !stop_det && !start_det)
    |=> (state == ST_DEV_ACK) && !ack_en)
    else $error("Slave address acknowledged while programming");
  wp_data_nack_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (state == ST_WDATA && byte_in && wp_s && !sup_s && !stop_det && !start_det)
    |=> !ack_en && $stable(got_data) && $stable(addr))
    else $error("Data byte taken while write-protected");
  page_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (push_valid && push_ready)
    |=> addr == {$past(addr[7:4]), $past(addr[3:0]) + 4'h1})
    else $error("Write address left its page");
  read_inc_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
    (state == ST_RACK && scl_fall && ack_en && !sup_s && !stop_det && !start_det)
    |=> state == ST_RDATA && addr == $past(addr) + 8'h01 && sda_oe == !$past(mem_rd[7]))
    else $error("Sequential read did not advance the counter");
  ack_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (state == ST_WADDR_ACK && scl_fall && !ack_phase && !sup_s && !stop_det
     && !start_det) |=> sda_oe && ack_phase)
    else $error("Memory address not acknowledged");
  master_ack_free_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    (state == ST_RACK) |-> !sda_oe)
    else $error("Data line driven during master acknowledge");
  nack_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (state == ST_RACK && scl_fall && !ack_en && !sup_s && !stop_det && !start_det)
    |=> state == ST_WAIT_STOP ##1 (!sda_oe [*4]))
    else $error("Read continued after no acknowledge");
  stop_prog_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    (stop_det && got_data && !busy && !sup_s) |=> busy ##1 busy)
    else $error("Programming did not start on STOP");
  sup_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
    (sup_s && busy) |=> state == ST_IDLE && !sda_oe && busy == !$past(prog_run
      && prog_cnt == CW'(PROG_CYC - 1)))
    else $error("Supervisor reset mishandled");

endmodule // eeprom_slave
`default_nettype wire

/* src/write_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
module write_fifo #(
  parameter int W = 12,
  parameter int D = 32
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] store [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // A word written into an empty FIFO must be offered on the next cycle.
  fifo_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (in_valid && in_ready && empty && !flush) |=> out_valid && out_data == $past(in_data))
    else $error("FIFO lost a word written while empty");

endmodule // write_fifo
`default_nettype wire

/* tb/i2c_master_model.sv */
// Two-wire bus master model: drives clock and an open-drain data line.
// Assumes the bench resolves data with a pull-up from both drivers.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Clock.
  input  wire logic clk,
  // Bus.
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic ph;

  // Called first by the bench, so every bus signal has a single driving process.
  task automatic init();
    scl <= 1'b1;
    sda_low <= 1'b0;
    ph = 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // data moves while clock is low, except in start and stop, which move it with clock high.
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    tick(2);
    sda_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(3);
    s = sda;
    // The high phase alternates 6 and 7 cycles, so the period averages 125 ns.
    tick(3 + ph);
    ph = ~ph;
  endtask

  task automatic start();
    tick(1);
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b1;
    tick(6);
  endtask

  task automatic stop();
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b0;
    tick(6);
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* tb/tb_eeprom_slave.sv */
// Self-checking bench for the serial EEPROM slave: writes, polling, reads.
// Assumes the master model and a pull-up on the resolved data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_slave
  import eeprom_pkg::*;
;
  localparam int         PROG  = 400;
  localparam logic [7:0] DEV_W = {DEV_TYPE_DEF, 4'h0};
  localparam logic [7:0] DEV_R = {DEV_TYPE_DEF, 4'hb};
  logic       clk;
  logic       rst_n;
  logic       wp_pin;
  logic       sup_reset;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       sda_out;
  logic       busy;
  wire        sda;
  logic [7:0] mem [256];
  logic [7:0] ptr;
  longint     t0;
  int         fails;
  int         tests_run;

  assign sda = ~sda_low & ~(sda_oe & ~sda_out);
  initial clk = 1'b0;
  always #5 clk = ~clk;

  eeprom_slave #(.PROG_CYC(PROG)) dut (
    .clk(clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_pin(wp_pin), .sup_reset(sup_reset), .busy(busy));
  i2c_master_model m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  // The shadow array models in-page wrap, so overwrites need no special case.
  task automatic do_write(input logic [7:0] a, input logic [7:0] d0, input int n,
                          input logic ok);
    logic       k;
    logic [7:0] v;
    m.start();
    m.send(DEV_W, k);
    check1(k, 1'b1);
    m.send(a, k);
    check1(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      v = d0 + 8'(i * 7);
      m.send(v, k);
      check1(k, ok);
      if (ok) mem[{a[7:4], a[3:0] + 4'(i)}] = v;
    end
    if (ok) ptr = {a[7:4], a[3:0] + 4'(n)};
    m.stop();
    #1;
    check1(busy, ok);
    t0 = $time;
  endtask

  task automatic wait_prog();
    for (int c = 0; c < 2000 && busy !== 1'b0; c++) begin
      @(posedge clk);
      #1;
    end
    check1(busy, 1'b0);
    check1((($time - t0) / 10) inside {[PROG - 12 : PROG + 12]}, 1'b1);
  endtask

  // One extra byte after the final nack must read as released bus.
  task automatic do_read(input logic rnd, input logic [7:0] a, input int n);
    logic       k;
    logic [7:0] b;
    if (rnd) begin
      m.start();
      m.send(DEV_W, k);
      m.send(a, k);
      check1(k, 1'b1);
      ptr = a;
    end
    m.start();
    m.send(DEV_R, k);
    check1(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.recv(i < n - 1, b);
      check8(b, mem[ptr]);
      ptr = ptr + 8'h01;
    end
    m.recv(1'b0, b);
    check8(b, 8'hff);
    m.stop();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_write_poll();
    logic k;
    do_write(8'h10, 8'h5a, 2, 1'b1);
    m.start();
    m.send(DEV_W, k);
    check1(k, 1'b0);
    m.stop();
    wait_prog();
    m.start();
    m.send(DEV_W, k);
    check1(k, 1'b1);
    m.stop();
    do_read(1'b1, 8'h10, 1);
    do_read(1'b0, 8'h00, 1);
    $display("test write_poll done");
  endtask

  task automatic t_page_wrap();
    do_write(8'h2e, 8'h31, 18, 1'b1);
    wait_prog();
    do_read(1'b0, 8'h00, 16);
    $display("test page_wrap done");
  endtask

  task automatic t_rollover();
    do_write(8'hf8, 8'hc3, 8, 1'b1);
    wait_prog();
    do_write(8'h00, 8'h19, 2, 1'b1);
    wait_prog();
    do_read(1'b1, 8'hfe, 4);
    $display("test rollover done");
  endtask

  task automatic t_protect();
    @(posedge clk);
    wp_pin <= 1'b1;
    do_write(8'h10, 8'hee, 1, 1'b0);
    @(posedge clk);
    wp_pin <= 1'b0;
    do_read(1'b1, 8'h10, 1);
    $display("test protect done");
  endtask

  task automatic t_bad_type();
    logic k;
    m.start();
    m.send({DEV_TYPE_DEF ^ 4'h1, 4'h0}, k);
    check1(k, 1'b0);
    m.stop();
    $display("test bad_type done");
  endtask

  task automatic t_supervisor();
    logic k;
    do_write(8'h40, 8'h77, 1, 1'b1);
    @(posedge clk);
    sup_reset <= 1'b1;
    wait_prog();
    m.start();
    m.send(DEV_W, k);
    check1(k, 1'b0);
    m.stop();
    @(posedge clk);
    sup_reset <= 1'b0;
    do_read(1'b1, 8'h40, 1);
    $display("test supervisor done");
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    wp_pin = 1'b0;
    sup_reset = 1'b0;
    m.init();
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check1(busy, 1'b0);
    check1(sda_oe, 1'b0);
    check1(sda_out, 1'b0);
    t_write_poll();
    t_page_wrap();
    t_rollover();
    t_protect();
    t_bad_type();
    t_supervisor();
    final_report();
  end

  // A hung handshake ends the run as a mismatch.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule // tb_eeprom_slave
`default_nettype wire
